// ### core/timer0_pkg.sv
// Summary of operation
// - cpu reads and writes the 8-bit counter directly; writes replace the count
// - a counter write blocks compare matches on the next timer tick
// - compare a value is matched with counter for interrupt and wave out a
// - compare b value is matched with counter for interrupt and wave out b
// - low registers answer at data address and at data address minus 0x20
// - extended registers from 0x60 answer only to data space accesses
// - match b flag, bit 2, sets when counter equals compare b value
// - match a flag, bit 1, sets when counter equals compare a value
// - overflow flag, bit 0, sets when the counter overflows
// - overflow condition depends on the three-bit waveform mode selection
// - each flag clears when the cpu executes its interrupt vector
// - writing one clears a flag; writing zero leaves it alone
// - interrupt requested when global enable, source enable and flag are set
// - irq mask at 0x6e: b enable bit 2, a bit 1, overflow bit 0, reset 0
// - forced compare changes wave output only, and only in non-pwm modes; no flag, no counter clear
package timer0_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [7:0] FLAGS_ADDR     = 8'h35;
  localparam logic [7:0] COUNTER_ADDR   = 8'h46;
  localparam logic [7:0] COMPARE_A_ADDR = 8'h47;
  localparam logic [7:0] COMPARE_B_ADDR = 8'h48;
  localparam logic [7:0] IRQ_MASK_ADDR  = 8'h6e;
  localparam logic [7:0] IO_OFFSET      = 8'h20;
  localparam logic [7:0] IO_LIMIT       = 8'h3f;
  localparam logic [7:0] EXT_BASE       = 8'h60;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int OVF_BIT     = 0;
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  localparam int NUM_FLAGS   = 3;
  localparam logic [7:0] COUNTER_RESET   = 8'h00;
  localparam logic [7:0] COMPARE_RESET   = 8'h00;
  localparam logic [2:0] FLAGS_RESET     = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET  = 3'h0;
  localparam logic [7:0] COUNT_MAX       = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM    = 8'h00;

  // ****************************************************************
  // waveform modes and output actions
  // ****************************************************************
  localparam logic [2:0] MODE_NORMAL     = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX  = 3'h1;
  localparam logic [2:0] MODE_CTC        = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX   = 3'h3;
  localparam logic [2:0] MODE_PHASE_CMPA = 3'h5;
  localparam logic [2:0] MODE_FAST_CMPA  = 3'h7;
  localparam logic [1:0] ACT_NONE        = 2'h0;
  localparam logic [1:0] ACT_TOGGLE      = 2'h1;
  localparam logic [1:0] ACT_CLEAR       = 2'h2;
  localparam logic [1:0] ACT_SET         = 2'h3;

endpackage : timer0_pkg

// ### core/flag_if.sv
`timescale 1ns/1ps
interface flag_if;
  logic [2:0] set;
  logic [2:0] w1c;
  logic [2:0] ack;
  logic [2:0] flags;

  modport owner (
    input  set,
    input  w1c,
    input  ack,
    output flags
  );
  modport user (
    output set,
    output w1c,
    output ack,
    input  flags
  );
endinterface : flag_if

// ### core/flag_unit.sv
`timescale 1ns/1ps
module flag_unit (
  input  wire logic clk_i,
  input  wire logic rst_i,
  flag_if.owner     fl
);

  logic [timer0_pkg::NUM_FLAGS-1:0] flags;

  // ****************************************************************
  // sticky flags, set beats clear
  // ****************************************************************
  for (genvar i = 0; i < timer0_pkg::NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        flags[i] <= 1'b0;
      end else if (fl.set[i]) begin
        flags[i] <= 1'b1;
      end else if (fl.w1c[i] || fl.ack[i]) begin
        flags[i] <= 1'b0;
      end
    end
  end

  assign fl.flags = flags;

endmodule : flag_unit

// ### core/compare_unit.sv
`timescale 1ns/1ps
module compare_unit #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             block_i,
  input  wire logic [WIDTH-1:0] count_i,
  input  wire logic [WIDTH-1:0] compare_i,
  input  wire logic             fast_i,
  input  wire logic             phase_i,
  input  wire logic             down_i,
  input  wire logic             wrap_i,
  input  wire logic [1:0]       action_i,
  input  wire logic             force_i,
  output logic                  match_o,
  output logic                  wave_o
);

  logic wave;
  logic pwm;

  assign pwm     = fast_i || phase_i;
  // equality only counts on a tick not blocked by a counter write
  assign match_o = tick_i && !block_i && (count_i == compare_i);

  // ****************************************************************
  // waveform output
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wave <= 1'b0;
    end else if (!pwm) begin
      if (match_o || force_i) begin
        unique case (action_i)
          timer0_pkg::ACT_NONE:   wave <= wave;
          timer0_pkg::ACT_TOGGLE: wave <= !wave;
          timer0_pkg::ACT_CLEAR:  wave <= 1'b0;
          timer0_pkg::ACT_SET:    wave <= 1'b1;
        endcase
      end
    end else if (action_i[1]) begin
      // pwm: action bit 0 selects inverted polarity
      if (match_o) begin
        wave <= action_i[0] ^ (phase_i && down_i);
      end else if (fast_i && wrap_i) begin
        wave <= !action_i[0];
      end
    end
  end

  assign wave_o = wave;

endmodule : compare_unit

// ### core/timer0_compare_and_flags.sv
`timescale 1ns/1ps
module timer0_compare_and_flags (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // cpu register port
  input  wire logic [7:0] addr_i,
  input  wire logic       io_space_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // timer control
  input  wire logic       tick_i,
  input  wire logic [2:0] waveform_mode_sel_i,
  input  wire logic [1:0] action_a_i,
  input  wire logic [1:0] action_b_i,
  input  wire logic       force_compare_a_strobe_i,
  input  wire logic       force_compare_b_strobe_i,
  // interrupt handshake
  input  wire logic       global_irq_enable_i,
  input  wire logic [2:0] vector_ack_i,
  output logic      [2:0] irq_o,
  // waveform pins
  output logic            wave_out_a_o,
  output logic            wave_out_b_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] data_addr;
  logic       addr_ok;
  logic       wr_counter;
  logic       wr_compare_a;
  logic       wr_compare_b;
  logic       wr_flags;
  logic       wr_mask;
  logic [7:0] counter_value;
  logic [7:0] next_counter;
  logic [7:0] compare_a_value;
  logic [7:0] compare_b_value;
  logic [2:0] timer_irq_mask;
  logic       count_down;
  logic       next_down;
  logic       block_match;
  logic [7:0] top_value;
  logic       fast_mode;
  logic       phase_mode;
  logic       at_top;
  logic       at_bottom;
  logic       wrap;
  logic       overflow;
  logic       match_a;
  logic       match_b;
  logic [7:0] read_value;
  logic [7:0] rdata;

  flag_if fl ();

  // ****************************************************************
  // address translation
  // ****************************************************************
  always_comb begin
    if (io_space_i) begin
      data_addr = addr_i + timer0_pkg::IO_OFFSET;
      // io accesses above 0x3f never reach the extended area
      addr_ok   = (addr_i <= timer0_pkg::IO_LIMIT);
    end else begin
      data_addr = addr_i;
      addr_ok   = 1'b1;
    end
  end

  // ****************************************************************
  // write strobes
  // ****************************************************************
  assign wr_counter   = wr_en_i && addr_ok
                        && (data_addr == timer0_pkg::COUNTER_ADDR);
  assign wr_compare_a = wr_en_i && addr_ok
                        && (data_addr == timer0_pkg::COMPARE_A_ADDR);
  assign wr_compare_b = wr_en_i && addr_ok
                        && (data_addr == timer0_pkg::COMPARE_B_ADDR);
  assign wr_flags     = wr_en_i && addr_ok
                        && (data_addr == timer0_pkg::FLAGS_ADDR);
  // mask sits in the extended area: data space only
  assign wr_mask      = wr_en_i && !io_space_i
                        && (addr_i == timer0_pkg::IRQ_MASK_ADDR);

  // ****************************************************************
  // compare registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      compare_a_value <= timer0_pkg::COMPARE_RESET;
    end else if (wr_compare_a) begin
      compare_a_value <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      compare_b_value <= timer0_pkg::COMPARE_RESET;
    end else if (wr_compare_b) begin
      compare_b_value <= wdata_i;
    end
  end

  // ****************************************************************
  // interrupt mask register
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_irq_mask <= timer0_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      timer_irq_mask <= wdata_i[2:0];
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  always_comb begin
    fast_mode  = (waveform_mode_sel_i == timer0_pkg::MODE_FAST_MAX)
                 || (waveform_mode_sel_i == timer0_pkg::MODE_FAST_CMPA);
    phase_mode = (waveform_mode_sel_i == timer0_pkg::MODE_PHASE_MAX)
                 || (waveform_mode_sel_i == timer0_pkg::MODE_PHASE_CMPA);
    if ((waveform_mode_sel_i == timer0_pkg::MODE_CTC)
        || (waveform_mode_sel_i == timer0_pkg::MODE_PHASE_CMPA)
        || (waveform_mode_sel_i == timer0_pkg::MODE_FAST_CMPA)) begin
      top_value = compare_a_value;
    end else begin
      top_value = timer0_pkg::COUNT_MAX;
    end
  end

  assign at_top    = (counter_value == top_value);
  assign at_bottom = (counter_value == timer0_pkg::COUNT_BOTTOM);

  // ****************************************************************
  // counter sequencing
  // ****************************************************************
  always_comb begin
    next_down    = 1'b0;
    next_counter = counter_value + 8'h01;
    if (phase_mode) begin
      next_down = count_down;
      if (!count_down && at_top) begin
        next_down = 1'b1;
      end else if (count_down && at_bottom) begin
        next_down = 1'b0;
      end
      if (next_down) begin
        next_counter = counter_value - 8'h01;
      end
    end else if (at_top) begin
      next_counter = timer0_pkg::COUNT_BOTTOM;
    end
  end

  // wrap marks the step from top back to bottom in single-slope modes
  assign wrap = tick_i && !phase_mode && at_top;

  // overflow point follows the waveform mode
  always_comb begin
    if (phase_mode) begin
      overflow = tick_i && count_down && at_bottom;
    end else if ((waveform_mode_sel_i == timer0_pkg::MODE_NORMAL)
                 || (waveform_mode_sel_i == timer0_pkg::MODE_CTC)) begin
      overflow = tick_i && (counter_value == timer0_pkg::COUNT_MAX);
    end else begin
      overflow = wrap;
    end
  end

  // ****************************************************************
  // counter register
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_value <= timer0_pkg::COUNTER_RESET;
    end else if (wr_counter) begin
      // a cpu write wins over a tick in the same cycle
      counter_value <= wdata_i;
    end else if (tick_i) begin
      counter_value <= next_counter;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_down <= 1'b0;
    end else if (!phase_mode) begin
      count_down <= 1'b0;
    end else if (tick_i && !wr_counter) begin
      count_down <= next_down;
    end
  end

  // ****************************************************************
  // match blocking after counter write
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_match <= 1'b0;
    end else if (wr_counter) begin
      block_match <= 1'b1;
    end else if (tick_i) begin
      block_match <= 1'b0;
    end
  end

  // ****************************************************************
  // compare units
  // ****************************************************************
  compare_unit #(
    .WIDTH (8)
  ) u_compare_a (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_i),
    .block_i   (block_match),
    .count_i   (counter_value),
    .compare_i (compare_a_value),
    .fast_i    (fast_mode),
    .phase_i   (phase_mode),
    .down_i    (count_down),
    .wrap_i    (wrap),
    .action_i  (action_a_i),
    .force_i   (force_compare_a_strobe_i),
    .match_o   (match_a),
    .wave_o    (wave_out_a_o)
  );

  compare_unit #(
    .WIDTH (8)
  ) u_compare_b (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_i),
    .block_i   (block_match),
    .count_i   (counter_value),
    .compare_i (compare_b_value),
    .fast_i    (fast_mode),
    .phase_i   (phase_mode),
    .down_i    (count_down),
    .wrap_i    (wrap),
    .action_i  (action_b_i),
    .force_i   (force_compare_b_strobe_i),
    .match_o   (match_b),
    .wave_o    (wave_out_b_o)
  );

  // ****************************************************************
  // event flags
  // ****************************************************************
  always_comb begin
    fl.set                          = 3'h0;
    fl.set[timer0_pkg::MATCH_B_BIT] = match_b;
    fl.set[timer0_pkg::MATCH_A_BIT] = match_a;
    fl.set[timer0_pkg::OVF_BIT]     = overflow;
  end

  // only the three low bits have an effect
  assign fl.w1c = wr_flags ? wdata_i[2:0] : 3'h0;
  assign fl.ack = vector_ack_i;

  flag_unit u_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .fl    (fl)
  );

  // ****************************************************************
  // interrupt requests
  // ****************************************************************
  assign irq_o = fl.flags & timer_irq_mask
                 & {3{global_irq_enable_i}};

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    read_value = 8'h00;
    if (!io_space_i && (addr_i == timer0_pkg::IRQ_MASK_ADDR)) begin
      read_value = {5'h00, timer_irq_mask};
    end else if (addr_ok) begin
      unique case (data_addr)
        timer0_pkg::COUNTER_ADDR:   read_value = counter_value;
        timer0_pkg::COMPARE_A_ADDR: read_value = compare_a_value;
        timer0_pkg::COMPARE_B_ADDR: read_value = compare_b_value;
        timer0_pkg::FLAGS_ADDR:     read_value = {5'h00, fl.flags};
        default:                    read_value = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else if (rd_en_i) begin
      rdata <= read_value;
    end
  end

  assign rdata_o = rdata;

endmodule : timer0_compare_and_flags

// ### verification/timer0_properties.sv
`timescale 1ns/1ps
// *****
// port-level checks
// *****
module timer0_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic       io_space_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       tick_i,
  input wire logic [2:0] waveform_mode_sel_i,
  input wire logic [1:0] action_a_i,
  input wire logic [1:0] action_b_i,
  input wire logic       force_compare_a_strobe_i,
  input wire logic       force_compare_b_strobe_i,
  input wire logic       global_irq_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic [2:0] irq_o,
  input wire logic       wave_out_a_o,
  input wire logic       wave_out_b_o
);
  logic [7:0] data_addr;
  logic       flag_wr;
  logic       cnt_sel;
  assign data_addr = io_space_i ? addr_i + timer0_pkg::IO_OFFSET : addr_i;
  assign flag_wr   = wr_en_i && data_addr == timer0_pkg::FLAGS_ADDR;
  assign cnt_sel   = data_addr == timer0_pkg::COUNTER_ADDR;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_irq_gated;
    !global_irq_enable_i |-> irq_o == 3'h0;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt request without global enable");

  property p_set_on_tick;
    (|(irq_o & ~$past(irq_o))) && $stable(global_irq_enable_i)
      && !$past(wr_en_i) |-> $past(tick_i);
  endproperty
  a_set_on_tick: assert property (p_set_on_tick)
    else $error("flag set without a timer tick");

  property p_ack_clear;
    !tick_i && vector_ack_i != 3'h0 |=> (irq_o & $past(vector_ack_i)) == 3'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("vector execution left its flag set");

  property p_w1c;
    flag_wr && !tick_i |=> (irq_o & $past(wdata_i[2:0])) == 3'h0;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("writing one did not clear the flag");

  property p_w0_keeps;
    (flag_wr && wdata_i[2:0] == 3'h0 && vector_ack_i == 3'h0
      && global_irq_enable_i) ##1 global_irq_enable_i
      |-> (irq_o & $past(irq_o)) == $past(irq_o);
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("writing zero cleared a flag");

  property p_ext_io;
    rd_en_i && io_space_i && addr_i > timer0_pkg::IO_LIMIT |=> rdata_o == 8'h00;
  endproperty
  a_ext_io: assert property (p_ext_io)
    else $error("i/o read above the i/o range returned data");

  property p_rdata_stands;
    !rd_en_i |=> $stable(rdata_o);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed without a read");

  property p_cnt_back;
    (wr_en_i && cnt_sel && !tick_i) ##1 (!tick_i && !wr_en_i)
      ##1 (rd_en_i && cnt_sel && !tick_i) |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_cnt_back: assert property (p_cnt_back)
    else $error("counter read back differs from value written");
endmodule : timer0_properties

bind timer0_compare_and_flags timer0_properties timer0_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .io_space_i(io_space_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .tick_i(tick_i),
  .waveform_mode_sel_i(waveform_mode_sel_i), .action_a_i(action_a_i),
  .action_b_i(action_b_i),
  .force_compare_a_strobe_i(force_compare_a_strobe_i),
  .force_compare_b_strobe_i(force_compare_b_strobe_i),
  .global_irq_enable_i(global_irq_enable_i), .vector_ack_i(vector_ack_i),
  .irq_o(irq_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o)
);

// ### verification/cpu_model.sv
`timescale 1ns/1ps
// *****
// cpu side of the register port
// *****
module cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            io_space_o,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] wdata_o,
  output logic            global_irq_enable_o,
  output logic      [2:0] vector_ack_o
);
  // bus idles low until the first access
  initial begin
    addr_o              = 8'h00;
    io_space_o          = 1'b0;
    wr_en_o             = 1'b0;
    rd_en_o             = 1'b0;
    wdata_o             = 8'h00;
    global_irq_enable_o = 1'b0;
    vector_ack_o        = 3'h0;
  end

  // daddr is always the data-space address
  task automatic access(input logic [7:0] daddr, input logic io,
                        input logic wr, input logic [7:0] data,
                        output logic [7:0] rd);
    @(negedge clk_i);
    io_space_o = io;
    addr_o     = io ? daddr - timer0_pkg::IO_OFFSET : daddr;
    wr_en_o    = wr;
    rd_en_o    = !wr;
    wdata_o    = data;
    @(negedge clk_i);
    rd      = rdata_i;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
  endtask : access

  task automatic set_gie(input logic en);
    @(negedge clk_i);
    global_irq_enable_o = en;
  endtask : set_gie

  task automatic ack(input logic [2:0] src);
    @(negedge clk_i);
    vector_ack_o = src;
    @(negedge clk_i);
    vector_ack_o = 3'h0;
  endtask : ack
endmodule : cpu_model

// ### verification/timer0_compare_and_flags_test.sv
`timescale 1ns/1ps
module timer0_compare_and_flags_test;
  localparam logic [7:0] FLG = timer0_pkg::FLAGS_ADDR;
  localparam logic [7:0] CNT = timer0_pkg::COUNTER_ADDR;
  localparam logic [7:0] CPA = timer0_pkg::COMPARE_A_ADDR;
  localparam logic [7:0] CPB = timer0_pkg::COMPARE_B_ADDR;
  localparam logic [7:0] MSK = timer0_pkg::IRQ_MASK_ADDR;
  logic       clk_i;
  logic       rst_i = 1'b1;
  logic [7:0] addr;
  logic       io_space;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       tick = 1'b0;
  logic [2:0] mode = timer0_pkg::MODE_NORMAL;
  logic [1:0] action_a = timer0_pkg::ACT_NONE;
  logic       force_a = 1'b0;
  logic [1:0] action_b = timer0_pkg::ACT_NONE;
  logic       force_b = 1'b0;
  logic       gie;
  logic [2:0] ack;
  logic [2:0] irq;
  logic       wave_a;
  logic       wave_b;
  logic       w;
  int         fails = 0;
  int         n_tests = 0;
  int         cycles = 0;
  logic [7:0] regs [5] = '{FLG, CNT, CPA, CPB, MSK};

  cpu_model cpu_model_i (
    .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .io_space_o(io_space),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .wdata_o(wdata),
    .global_irq_enable_o(gie), .vector_ack_o(ack)
  );

  timer0_compare_and_flags timer0_compare_and_flags_i (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .io_space_i(io_space),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
    .tick_i(tick), .waveform_mode_sel_i(mode), .action_a_i(action_a),
    .action_b_i(action_b), .force_compare_a_strobe_i(force_a),
    .force_compare_b_strobe_i(force_b), .global_irq_enable_i(gie),
    .vector_ack_i(ack), .irq_o(irq), .wave_out_a_o(wave_a),
    .wave_out_b_o(wave_b)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // *****
  // helpers
  // *****
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    logic [7:0] x;
    cpu_model_i.access(a, io, 1'b1, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic io, input logic [7:0] exp);
    logic [7:0] x;
    cpu_model_i.access(a, io, 1'b0, 8'h00, x);
    check(what, exp, x);
  endtask : rd_chk

  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk_i);
      tick = 1'b1;
      @(negedge clk_i);
      tick = 1'b0;
    end
  endtask : step

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end

  // *****
  // main sequence
  // *****
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    foreach (regs[i]) rd_chk("reset value", regs[i], 1'b0, 8'h00);
    wr(CPA, 1'b1, 8'h10);
    wr(CPB, 1'b0, 8'hff);
    wr(MSK, 1'b0, 8'h07);
    rd_chk("compare a", CPA, 1'b0, 8'h10);
    rd_chk("compare b", CPB, 1'b1, 8'hff);
    wr(MSK, 1'b1, 8'h00);
    rd_chk("mask after io write", MSK, 1'b0, 8'h07);
    rd_chk("mask via io", MSK, 1'b1, 8'h00);
    cpu_model_i.set_gie(1'b1);
    // counter only rewritten between ticks
    wr(CNT, 1'b1, 8'h10);
    step(1);
    rd_chk("flags after blocked match", FLG, 1'b0, 8'h00);
    rd_chk("counter", CNT, 1'b1, 8'h11);
    wr(CNT, 1'b0, 8'h0f);
    step(2);
    rd_chk("flags after match a", FLG, 1'b1, 8'h02);
    check("irq match a", 8'h02, {5'h00, irq});
    cpu_model_i.set_gie(1'b0);
    #1;
    check("irq masked globally", 8'h00, {5'h00, irq});
    cpu_model_i.set_gie(1'b1);
    wr(FLG, 1'b0, 8'h00);
    rd_chk("flags after zero write", FLG, 1'b0, 8'h02);
    wr(FLG, 1'b1, 8'hfa);
    rd_chk("flags after one write", FLG, 1'b0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      mode = k ? timer0_pkg::MODE_FAST_MAX : timer0_pkg::MODE_NORMAL;
      wr(CNT, 1'b0, 8'hfe);
      rd_chk("counter written", CNT, 1'b0, 8'hfe);
      step(2);
      rd_chk("flags at wrap", FLG, 1'b1, 8'h05);
      check("irq at wrap", 8'h05, {5'h00, irq});
      cpu_model_i.ack(3'h1);
      rd_chk("flags after ovf vector", FLG, 1'b0, 8'h04);
      cpu_model_i.ack(3'h4);
      rd_chk("flags after b vector", FLG, 1'b0, 8'h00);
    end
    mode = timer0_pkg::MODE_PHASE_MAX;
    wr(CNT, 1'b0, 8'hfe);
    step(2);
    rd_chk("flags in phase mode", FLG, 1'b0, 8'h04);
    rd_chk("counter turned down", CNT, 1'b0, 8'hfe);
    wr(FLG, 1'b0, 8'h07);
    mode = timer0_pkg::MODE_CTC;
    wr(CNT, 1'b0, 8'h0f);
    step(2);
    rd_chk("flags in ctc", FLG, 1'b0, 8'h02);
    rd_chk("counter after ctc top", CNT, 1'b0, 8'h00);
    wr(FLG, 1'b0, 8'h07);
    mode = timer0_pkg::MODE_NORMAL;
    action_a = timer0_pkg::ACT_TOGGLE;
    action_b = timer0_pkg::ACT_SET;
    wr(CNT, 1'b0, 8'h33);
    check("wave b before force", 8'h00, {7'h00, wave_b});
    w = wave_a;
    @(negedge clk_i);
    force_a = 1'b1;
    force_b = 1'b1;
    @(negedge clk_i);
    force_a = 1'b0;
    force_b = 1'b0;
    check("wave a after force", {7'h00, ~w}, {7'h00, wave_a});
    check("wave b after force", 8'h01, {7'h00, wave_b});
    rd_chk("flags after force", FLG, 1'b0, 8'h00);
    rd_chk("counter after force", CNT, 1'b0, 8'h33);
    wr(CNT, 1'b0, 8'h0f);
    step(2);
    check("wave a after match", {7'h00, w}, {7'h00, wave_a});
    complete_run();
  end
endmodule : timer0_compare_and_flags_test
